// ==== include/tcc_pkg.sv ====
// constants and register map of the capture/compare channel
package tcc_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register addresses (word index)
  localparam logic [3:0] ADDR_COUNTER = 4'h0;
  localparam logic [3:0] ADDR_GRA = 4'h1;
  localparam logic [3:0] ADDR_GRB = 4'h2;
  localparam logic [3:0] ADDR_GRC = 4'h3;
  localparam logic [3:0] ADDR_GRD = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_CLEAR = 4'h6;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
  localparam logic [3:0] ADDR_OUT_EN = 4'h8;
  localparam logic [3:0] ADDR_OUT_LVL = 4'h9;
  localparam logic [3:0] ADDR_IO_AB = 4'hA;
  localparam logic [3:0] ADDR_IO_CD = 4'hB;
  localparam logic [3:0] ADDR_RUN = 4'hC;
  // status bit positions
  localparam int ST_CAPA = 0;
  localparam int ST_OVF = 1;
  localparam int ST_CMPB = 2;
  localparam int ST_CMPD = 3;
  localparam int ST_W = 4;
  // output enable register: bit low enables the pin
  localparam int OE_A = 0;
  localparam int OE_B = 1;
  localparam int OE_C = 2;
  localparam int OE_D = 3;
  // output level control: initial level bits
  localparam int LVL_B = 1;
  localparam int LVL_D = 3;
  // io control fields: compare mode select and high-on-match
  localparam int IO_HI_BIT = 1;
  localparam int IO_MODE_BIT = 5;
  localparam int IO_HI_D_BIT = 5;
  localparam int IO_MODE_D_BIT = 7;
  // reset values as configured
  localparam logic [7:0] RST_OUT_EN = 8'hF5;
  localparam logic [7:0] RST_OUT_LVL = 8'h00;
  localparam logic [7:0] RST_IO_AB = 8'h26;
  localparam logic [7:0] RST_IO_CD = 8'hAC;
  localparam logic [15:0] RST_GRB = 16'h3FFF;
  localparam logic [15:0] RST_GRD = 16'h7FFF;
  localparam logic [3:0] RST_IRQ_EN = 4'h3;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam int FILT_LEN = 3;
endpackage

// ==== design/tcc_chan0.sv ====
// capture/compare channel 0 of the free-running 16-bit timer
`timescale 1ns/1ps
module tcc_chan0 (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tcc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tcc_pkg::DATA_W-1:0] reg_rdata,
  // pins
  input wire logic capture_in_pin_a,
  output logic compare_out_pin_b,
  output logic compare_out_pin_b_oe_n,
  output logic compare_out_pin_d,
  output logic compare_out_pin_d_oe_n,
  // interrupt
  output logic chan0_irq
);
  import tcc_pkg::*;

  logic [CNT_W-1:0] chan0_counter_ff;
  logic [CNT_W-1:0] general_reg_a_ff, general_reg_b_ff, general_reg_c_ff, general_reg_d_ff;
  logic [ST_W-1:0] status_ff, irq_en_ff, nxt_status;
  logic [ST_W-1:0] nxt_irq_en;
  logic cnt_wr, irq_ff;
  logic [7:0] output_enable_reg_ff, output_level_ctrl_ff, io_ctrl_a_b_ff, io_ctrl_c_d_ff;
  logic run_ff;
  logic [FILT_LEN-1:0] sync_ff;
  logic filt_ff, filt_prev_ff;
  logic pin_b_ff, pin_d_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic cap_evt, ovf_evt, match_b, match_d;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  // free counting
  // a software write to the counter wins over the count in that cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      chan0_counter_ff <= CNT_ZERO;
    end else if (wr_hit(ADDR_COUNTER)) begin
      chan0_counter_ff <= reg_wdata;
    end else if (run_ff) begin
      chan0_counter_ff <= chan0_counter_ff + CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      run_ff <= 1'b1;
    end else if (wr_hit(ADDR_RUN)) begin
      run_ff <= reg_wdata[0];
    end
  end

  // plain nets here: a continuous assignment does not see signals read inside a function
  assign cnt_wr = reg_wr && (reg_addr == ADDR_COUNTER);
  assign ovf_evt = run_ff && (chan0_counter_ff == CNT_MAX) && !cnt_wr;

  // three-stage filter
  // first stage feeds only the second; the level changes once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= {sync_ff[FILT_LEN-2:0], capture_in_pin_a};
    end
  end

  // a pulse shorter than two sample periods never reaches the capture logic
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      filt_ff <= 1'b0;
    end else if (sync_ff[1] == sync_ff[2]) begin
      filt_ff <= sync_ff[2];
    end
  end

  // reset level assumes an idle-low pin; a pin idling high gives one capture after reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      filt_prev_ff <= 1'b0;
    end else begin
      filt_prev_ff <= filt_ff;
    end
  end

  assign cap_evt = filt_ff ^ filt_prev_ff;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      general_reg_a_ff <= CNT_ZERO;
    end else if (cap_evt) begin
      general_reg_a_ff <= chan0_counter_ff;
    end else if (wr_hit(ADDR_GRA)) begin
      general_reg_a_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      general_reg_b_ff <= RST_GRB;
    end else if (wr_hit(ADDR_GRB)) begin
      general_reg_b_ff <= reg_wdata;
    end
  end

  // register c never buffers register a in this mode
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      general_reg_c_ff <= CNT_ZERO;
    end else if (wr_hit(ADDR_GRC)) begin
      general_reg_c_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      general_reg_d_ff <= RST_GRD;
    end else if (wr_hit(ADDR_GRD)) begin
      general_reg_d_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      output_enable_reg_ff <= RST_OUT_EN;
    end else if (wr_hit(ADDR_OUT_EN)) begin
      output_enable_reg_ff <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      output_level_ctrl_ff <= RST_OUT_LVL;
    end else if (wr_hit(ADDR_OUT_LVL)) begin
      output_level_ctrl_ff <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_ctrl_a_b_ff <= RST_IO_AB;
    end else if (wr_hit(ADDR_IO_AB)) begin
      io_ctrl_a_b_ff <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_ctrl_c_d_ff <= RST_IO_CD;
    end else if (wr_hit(ADDR_IO_CD)) begin
      io_ctrl_c_d_ff <= reg_wdata[7:0];
    end
  end

  always_comb begin
    nxt_irq_en = irq_en_ff;
    if (wr_hit(ADDR_IRQ_EN)) begin
      nxt_irq_en = reg_wdata[ST_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_en_ff <= RST_IRQ_EN;
    end else begin
      irq_en_ff <= nxt_irq_en;
    end
  end

  // compares run on every count, even once the pin is already high
  assign match_b = io_ctrl_a_b_ff[IO_MODE_BIT] && (chan0_counter_ff == general_reg_b_ff);
  assign match_d = io_ctrl_c_d_ff[IO_MODE_D_BIT] && (chan0_counter_ff == general_reg_d_ff);

  // set-once outputs
  // a write to level control reloads the initial level; later matches only drive high
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_b_ff <= RST_OUT_LVL[LVL_B];
    end else if (wr_hit(ADDR_OUT_LVL)) begin
      pin_b_ff <= reg_wdata[LVL_B];
    end else if (match_b && io_ctrl_a_b_ff[IO_HI_BIT]) begin
      pin_b_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_d_ff <= RST_OUT_LVL[LVL_D];
    end else if (wr_hit(ADDR_OUT_LVL)) begin
      pin_d_ff <= reg_wdata[LVL_D];
    end else if (match_d && io_ctrl_c_d_ff[IO_HI_D_BIT]) begin
      pin_d_ff <= 1'b1;
    end
  end

  assign compare_out_pin_b = pin_b_ff;
  assign compare_out_pin_d = pin_d_ff;
  assign compare_out_pin_b_oe_n = output_enable_reg_ff[OE_B];
  assign compare_out_pin_d_oe_n = output_enable_reg_ff[OE_D];

  always_comb begin
    nxt_status = status_ff;
    if (wr_hit(ADDR_CLEAR)) begin
      nxt_status = nxt_status & ~reg_wdata[ST_W-1:0];
    end
    if (cap_evt) begin
      nxt_status[ST_CAPA] = 1'b1;
    end
    if (ovf_evt) begin
      nxt_status[ST_OVF] = 1'b1;
    end
    if (match_b) begin
      nxt_status[ST_CMPB] = 1'b1;
    end
    if (match_d) begin
      nxt_status[ST_CMPD] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // enable mask gates irq
  // built from next-state values, so the flop moves on the same edge as the flags
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & nxt_irq_en);
    end
  end

  assign chan0_irq = irq_ff;

  // read port: unmapped addresses return zero
  // zero outside the answer cycle, so several ports can be ORed onto one bus
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_COUNTER) begin
        rdata_ff <= chan0_counter_ff;
      end else if (reg_addr == ADDR_GRA) begin
        rdata_ff <= general_reg_a_ff;
      end else if (reg_addr == ADDR_GRB) begin
        rdata_ff <= general_reg_b_ff;
      end else if (reg_addr == ADDR_GRC) begin
        rdata_ff <= general_reg_c_ff;
      end else if (reg_addr == ADDR_GRD) begin
        rdata_ff <= general_reg_d_ff;
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_ff <= {{(DATA_W-ST_W){1'b0}}, status_ff};
      end else if (reg_addr == ADDR_IRQ_EN) begin
        rdata_ff <= {{(DATA_W-ST_W){1'b0}}, irq_en_ff};
      end else if (reg_addr == ADDR_OUT_EN) begin
        rdata_ff <= {8'h00, output_enable_reg_ff};
      end else if (reg_addr == ADDR_OUT_LVL) begin
        rdata_ff <= {8'h00, output_level_ctrl_ff};
      end else if (reg_addr == ADDR_IO_AB) begin
        rdata_ff <= {8'h00, io_ctrl_a_b_ff};
      end else if (reg_addr == ADDR_IO_CD) begin
        rdata_ff <= {8'h00, io_ctrl_c_d_ff};
      end else if (reg_addr == ADDR_RUN) begin
        rdata_ff <= {15'h0000, run_ff};
      end else begin
        rdata_ff <= '0;
      end
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule // tcc_chan0

// ==== verification/tcc_chan0_props.sv ====
// assertion checker for the capture/compare channel
`timescale 1ns/1ps
module tcc_chan0_props (
  // clock, reset and register port
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // pins and interrupt
  input wire logic capture_in_pin_a,
  input wire logic compare_out_pin_b,
  input wire logic compare_out_pin_b_oe_n,
  input wire logic compare_out_pin_d,
  input wire logic compare_out_pin_d_oe_n,
  input wire logic chan0_irq
);
  import tcc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic cw;
  logic lw;
  assign cw = reg_wr && reg_addr == ADDR_COUNTER;
  assign lw = reg_wr && reg_addr == ADDR_OUT_LVL;
  property p_start; $past(sys_rst) |-> !compare_out_pin_b && !compare_out_pin_d; endproperty
  a_start: assert property (p_start) else $error("pin not low after reset");
  property p_oe; $past(sys_rst) |-> !compare_out_pin_b_oe_n && !compare_out_pin_d_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("outputs not enabled");
  property p_holdb; compare_out_pin_b && !lw |=> compare_out_pin_b; endproperty
  a_holdb: assert property (p_holdb) else $error("pin b dropped");
  property p_holdd; compare_out_pin_d && !lw |=> compare_out_pin_d; endproperty
  a_holdd: assert property (p_holdd) else $error("pin d dropped");
  property p_cmpb; cw && reg_wdata == 16'h3FF0 |-> ##[16:18] compare_out_pin_b; endproperty
  a_cmpb: assert property (p_cmpb) else $error("pin b missed match");
  property p_cmpd; cw && reg_wdata == 16'h7FF0 |-> ##[16:18] compare_out_pin_d; endproperty
  a_cmpd: assert property (p_cmpd) else $error("pin d missed match");
  property p_ovf; cw && reg_wdata == 16'hFFF0 |-> ##[16:19] chan0_irq; endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow request");
  property p_cap; $changed(capture_in_pin_a) ##1 $stable(capture_in_pin_a) [*6] |-> chan0_irq;
  endproperty
  a_cap: assert property (p_cap) else $error("no capture request");
endmodule // tcc_chan0_props

bind tcc_chan0 tcc_chan0_props i_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .capture_in_pin_a(capture_in_pin_a), .chan0_irq(chan0_irq),
  .compare_out_pin_b(compare_out_pin_b), .compare_out_pin_b_oe_n(compare_out_pin_b_oe_n),
  .compare_out_pin_d(compare_out_pin_d), .compare_out_pin_d_oe_n(compare_out_pin_d_oe_n));

// ==== verification/tcc_pulse_src.sv ====
// external pulse source driving the capture pin
`timescale 1ns/1ps
module tcc_pulse_src (
  // clock and control
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [15:0] hi_len,
  // pin
  output logic pin
);
  logic [15:0] left;
  initial pin = 1'b0;
  initial left = 16'h0000;
  // steps land just after an edge, so the high time is exactly hi_len cycles
  always @(posedge clk_sys) begin
    if (go) begin
      pin <= 1'b1;
      left <= hi_len;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
      pin <= (left != 16'h0001);
    end
  end
endmodule // tcc_pulse_src

// ==== verification/test_tcc_chan0.sv ====
// self-checking bench for the capture/compare channel
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module test_tcc_chan0;
  import tcc_pkg::*;
  logic clk_sys, sys_rst, reg_wr, reg_rd, go, pin_a, pin_b, oe_b, pin_d, oe_d, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, hi_len, v, c1;
  int fails, n_compared, seed, tally;
  logic [19:0] tb [11] = '{20'h23FFF, 20'h47FFF, 20'h50000, 20'h70003, 20'h800F5,
    20'h90000, 20'hA0026, 20'hB00AC, 20'hC0001, 20'hD0000, 20'h60000};
  tcc_chan0 i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_in_pin_a(pin_a), .compare_out_pin_b(pin_b), .compare_out_pin_b_oe_n(oe_b),
    .compare_out_pin_d(pin_d), .compare_out_pin_d_oe_n(oe_d), .chan0_irq(irq));
  tcc_pulse_src i_src (.clk_sys(clk_sys), .go(go), .hi_len(hi_len), .pin(pin_a));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // software service: tally overflows, time both edges of one pulse
  task automatic measure(input logic [15:0] w);
    int n;
    logic [15:0] st;
    n = 0;
    go <= 1'b1;
    hi_len <= w;
    @(posedge clk_sys);
    go <= 1'b0;
    for (int k = 0; k < 2000 && n < 2; k++) begin
      @(posedge clk_sys);
      if (irq === 1'b1) begin
        rd(ADDR_STATUS, st);
        if (st[ST_OVF] === 1'b1) begin
          tally++;
          wr(ADDR_CLEAR, 16'h0002);
        end
        if (st[ST_CAPA] === 1'b1) begin
          rd(ADDR_GRA, v);
          wr(ADDR_CLEAR, 16'h0001);
          if (n == 1) `CHK(32'(tally) * 32'h10000 + 32'(v) - 32'(c1), 32'(w))
          c1 = v;
          tally = 0;
          n++;
        end
      end
    end
    `CHK(n, 2)
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  initial begin
    seed = 32'h7CBDF841;
    {sys_rst, reg_wr, reg_rd, go, reg_addr, reg_wdata, hi_len} = {4'h8, 36'h0};
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      rd(tb[i][19:16], v);
      `CHK(v, tb[i][15:0])
    end
    `CHK({pin_b, pin_d, oe_b, oe_d}, 4'h0)
    wr(ADDR_STATUS, 16'h000F);
    rd(ADDR_STATUS, v);
    `CHK(v, 16'h0000)
    wr(ADDR_GRC, 16'($random(seed)));
    rd(ADDR_GRC, c1);
    `CHK(c1, reg_wdata)
    wr(ADDR_COUNTER, 16'hFFE0);
    measure(16'h0040);
    repeat (4) measure(16'h0028 + (16'($random(seed)) & 16'h00FF));
    wr(ADDR_CLEAR, 16'h000F);
    wr(ADDR_COUNTER, 16'h3FF0);
    #1 `CHK(pin_b, 1'b0)
    repeat (30) @(posedge clk_sys);
    #1 `CHK({pin_b, irq}, 2'b10)
    rd(ADDR_COUNTER, v);
    `CHK(v > 16'h4000, 1'b1)
    wr(ADDR_COUNTER, 16'h7FF0);
    repeat (30) @(posedge clk_sys);
    #1 `CHK(pin_d, 1'b1)
    wr(ADDR_COUNTER, 16'hFFF0);
    repeat (30) @(posedge clk_sys);
    #1 `CHK(irq, 1'b1)
    wr(ADDR_IRQ_EN, 16'h0000);
    #1 `CHK(irq, 1'b0)
    wr(ADDR_IRQ_EN, 16'h0003);
    wr(ADDR_COUNTER, 16'h3FF0);
    repeat (30) @(posedge clk_sys);
    #1 `CHK({pin_b, pin_d, irq}, 3'b111)
    end_of_test();
  end
endmodule // test_tcc_chan0
